/* core/ssc_pkg.sv */
package ssc_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int          SSC_AW        = 8;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_LEVEL     = 8'h04;
    localparam logic [7:0]  OFF_CLKSEL    = 8'h08;
    localparam logic [7:0]  OFF_WAKEDIS   = 8'h0c;
    localparam logic [7:0]  OFF_OSTCNT    = 8'h10;
    localparam logic [7:0]  OFF_STATUS    = 8'h14;

    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int          CTRL_STOP     = 0;
    localparam int          CTRL_SUB      = 1;
    localparam logic [7:0]  LEVEL_LOWV    = 8'h01;
    localparam logic [7:0]  LEVEL_RST     = 8'h00;
    localparam int          CS_IT_LSB     = 0;
    localparam int          CS_WD_LSB     = 2;
    localparam int          CS_WT_SUB     = 4;
    localparam logic [1:0]  SEL_MAIN      = 2'h0;
    localparam logic [1:0]  SEL_INTOSC8   = 2'h1;
    localparam logic [1:0]  SEL_SUB       = 2'h2;
    localparam int          DIS_NMI       = 0;
    localparam int          DIS_WDT       = 1;
    localparam int          DIS_MASKABLE  = 2;
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_LOWV       = 4;
    localparam int          ST_ADC_INV    = 5;
    localparam int          ST_ABORT      = 6;
    localparam int          ST_CAUSE_LSB  = 8;
    localparam logic [1:0]  CAUSE_NONE    = 2'h0;
    localparam logic [1:0]  CAUSE_IRQ     = 2'h1;
    localparam logic [1:0]  CAUSE_RESET   = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          SSC_CNT_W      = 16;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          OST_TIME_NS    = 2000000;
    localparam int          OST_CYCLES     = OST_TIME_NS / CLK_PERIOD_NS;
    localparam int          DAC_SETTLE_NS  = 10000;
    localparam logic [SSC_CNT_W-1:0] DAC_SETTLE_CYC =
        SSC_CNT_W'((DAC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    localparam int          N_EXT = 8;
    localparam int          N_INT = 4;

    typedef enum logic [2:0] {
        SSC_RUN  = 3'h1,
        SSC_STOP = 3'h2,
        SSC_STAB = 3'h4
    } ssc_state_t;

    typedef struct packed {
        logic             nmi_pin;
        logic             watchdog_interrupt_event;
        logic [N_EXT-1:0] external_interrupt_pin;
        logic [N_EXT-1:0] ext_mask;
        logic [N_INT-1:0] int_irq;
        logic [N_INT-1:0] int_mask;
        logic [N_INT-1:0] int_live;
    } ssc_wake_src_t;

    typedef struct packed {
        logic ext_reset_pin;
        logic watchdog_reset_event;
        logic low_voltage_detector;
    } ssc_reset_src_t;

    typedef struct packed {
        logic cpu_halt;
        logic osc_stop;
        logic intc_stop;
        logic realtime_out_hold;
        logic port_hold;
        logic regulator_low;
        logic itimer_run;
        logic wdt_run;
        logic watch_run;
        logic serial_halt;
        logic adc_halt;
        logic dac_halt;
    } ssc_unit_ctl_t;

endpackage

/* core/ssc_delay_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module ssc_delay_timer
    import ssc_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 start,
    input  wire logic [SSC_CNT_W-1:0] load,
    output var  logic                 busy,
    output var  logic                 done
);
    // ----------------------------------------------------------------
    // Down counter, load of zero behaves as one cycle
    // ----------------------------------------------------------------
    logic [SSC_CNT_W-1:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            busy      <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_reg <= load;
                busy      <= 1'b1;
            end else if (busy) begin
                if (count_reg <= SSC_CNT_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg - SSC_CNT_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* core/ssc_standby_ctrl.sv */
// Notes on behaviour
// - Plain stop halts running ADC; pre-entry and first post-release results invalid.
// - Plain stop halts DAC, floats pin; resumes and restores level after settling.
// - Low-voltage stop halts ADC; all results before and after stay invalid.
// - Low-voltage stop halts DAC; resumes and restores level after settling.
// - Interrupt controller stops in standby but still detects wake requests.
// - Low-voltage stop keeps timers only on internal-osc/8 or used subclock.
// - Watch timer stops unless subclock used and selected as its clock.
// - Real-time output freezes and holds pin values during stop.
// - ADC halted in stop; result register undefined until restart.
// - Low-voltage stop preserves port pin states and CPU registers.
// - Stop ends on enabled NMI, watchdog interrupt, unmasked external or internal.
// - Stop ends on pin reset, watchdog reset or low-voltage detector.
// - After release wait oscillation stabilization before normal operation.
// - Stop request with pending unmasked interrupt is not entered; code still enters stop on it when DIS_MASKABLE is set.
// - Sources disabled by power-save disable bits never wake the device.
// - Level register 01h at request selects low-voltage stop, regulator drops.
// - Interrupt release returns regulator to normal level automatically.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ssc_standby_ctrl
    import ssc_pkg::*;
#(
    parameter logic [SSC_CNT_W-1:0] OST_DEFAULT = SSC_CNT_W'(OST_CYCLES)
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [SSC_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire ssc_wake_src_t     wake_src,
    input  wire ssc_reset_src_t    reset_src,
    input  wire logic              adc_running,
    input  wire logic              adc_conv_done,
    input  wire logic              dac_running,
    output var  ssc_unit_ctl_t     unit_ctl,
    output var  logic              adc_restart,
    output var  logic              adc_result_invalid,
    output var  logic              dac_out_en,
    output var  logic              dac_restore,
    output var  logic              reset_proc_req,
    output var  logic              stop_aborted
);
    // ----------------------------------------------------------------
    // Wake and reset decode
    // ----------------------------------------------------------------
    function automatic logic wake_hit(input ssc_wake_src_t s, input logic [2:0] dis);
        logic nmi;
        logic mask;
        nmi  = (s.nmi_pin && !dis[DIS_NMI])
             || (s.watchdog_interrupt_event && !dis[DIS_WDT]);
        mask = |(s.external_interrupt_pin & ~s.ext_mask)
             || |(s.int_irq & ~s.int_mask & s.int_live);
        return nmi || (mask && !dis[DIS_MASKABLE]);
    endfunction

    function automatic logic timer_keeps(input logic [1:0] sel, input logic sub);
        return (sel == SEL_INTOSC8) || (sub && sel == SEL_SUB);
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    ssc_state_t           state_reg;
    ssc_state_t           state_next;
    logic                 sub_used_reg;
    logic [7:0]           level_reg;
    logic [4:0]           clksel_reg;
    logic [2:0]           wakedis_reg;
    logic [SSC_CNT_W-1:0] ost_reg;
    logic                 lowv_reg;
    logic                 adc_was_reg;
    logic                 dac_was_reg;
    logic                 adc_first_reg;
    logic                 adc_sticky_reg;
    logic                 abort_reg;
    logic [1:0]           cause_reg;
    logic                 wake_now;
    logic                 rst_now;
    logic                 wr_en;
    logic                 stop_cmd;
    logic                 enter_stop;
    logic                 release_irq;
    logic                 leave_stab;
    logic                 ost_done;
    logic                 dac_busy;
    logic                 dac_done;
    logic                 in_standby;
    logic [31:0]          rd_mux;
    logic                 rd_err;

    assign wake_now    = wake_hit(wake_src, wakedis_reg);
    assign rst_now     = reset_src.ext_reset_pin || reset_src.watchdog_reset_event
                       || reset_src.low_voltage_detector;
    assign wr_en       = psel && penable && pready && pwrite;
    assign stop_cmd    = wr_en && paddr == OFF_CTRL && pwdata[CTRL_STOP];
    assign enter_stop  = state_reg == SSC_RUN && stop_cmd && !wake_now;
    assign release_irq = state_reg == SSC_STOP && wake_now && !rst_now;
    assign leave_stab  = state_reg == SSC_STAB && ost_done && !rst_now;
    assign in_standby  = state_next != SSC_RUN;

    // ----------------------------------------------------------------
    // Standby sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSC_RUN: begin
                if (enter_stop) begin
                    state_next = SSC_STOP;
                end
            end
            SSC_STOP: begin
                if (rst_now) begin
                    state_next = SSC_RUN;
                end else if (wake_now) begin
                    state_next = SSC_STAB;
                end
            end
            SSC_STAB: begin
                if (rst_now || ost_done) begin
                    state_next = SSC_RUN;
                end
            end
            default: begin
                state_next = SSC_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SSC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Oscillation stabilization; a reset during it drops the wait
    ssc_delay_timer u_ost (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (release_irq),
        .load    (ost_reg),
        .busy    (),
        .done    (ost_done)
    );

    // ----------------------------------------------------------------
    // Mode capture at entry
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowv_reg    <= 1'b0;
            adc_was_reg <= 1'b0;
            dac_was_reg <= 1'b0;
        end else if (enter_stop) begin
            lowv_reg    <= level_reg == LEVEL_LOWV;
            adc_was_reg <= adc_running;
            dac_was_reg <= dac_running;
        end else if (release_irq || rst_now) begin
            lowv_reg    <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_reg    <= 1'b0;
            stop_aborted <= 1'b0;
            cause_reg    <= CAUSE_NONE;
        end else begin
            stop_aborted <= state_reg == SSC_RUN && stop_cmd && wake_now;
            if (state_reg == SSC_RUN && stop_cmd && wake_now) begin
                abort_reg <= 1'b1;
            end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_ABORT]) begin
                abort_reg <= 1'b0;
            end
            if (state_reg != SSC_RUN && rst_now) begin
                cause_reg <= CAUSE_RESET;
            end else if (release_irq) begin
                cause_reg <= CAUSE_IRQ;
            end
        end
    end

    // ----------------------------------------------------------------
    // Unit control registered from the next state; reset_proc_req from the current state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_ctl       <= '0;
            reset_proc_req <= 1'b0;
        end else begin
            unit_ctl.cpu_halt      <= in_standby;
            unit_ctl.osc_stop      <= state_next == SSC_STOP;
            unit_ctl.intc_stop     <= in_standby;
            unit_ctl.realtime_out_hold <= in_standby;
            unit_ctl.port_hold     <= in_standby;
            unit_ctl.regulator_low <= state_next == SSC_STOP
                                   && (enter_stop ? level_reg == LEVEL_LOWV
                                                  : lowv_reg);
            unit_ctl.itimer_run    <= !in_standby
                || timer_keeps(clksel_reg[CS_IT_LSB +: 2], sub_used_reg);
            unit_ctl.wdt_run       <= !in_standby
                || timer_keeps(clksel_reg[CS_WD_LSB +: 2], sub_used_reg);
            unit_ctl.watch_run     <= !in_standby
                || (sub_used_reg && clksel_reg[CS_WT_SUB]);
            unit_ctl.serial_halt   <= in_standby;
            unit_ctl.adc_halt      <= in_standby;
            unit_ctl.dac_halt      <= in_standby;
            reset_proc_req         <= state_reg != SSC_RUN && rst_now;
        end
    end

    // ----------------------------------------------------------------
    // Converter side effects
    // ----------------------------------------------------------------
    // Settling runs after the stabilization wait; level held until done
    ssc_delay_timer u_dac_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (leave_stab && dac_was_reg),
        .load    (DAC_SETTLE_CYC),
        .busy    (dac_busy),
        .done    (dac_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_out_en  <= 1'b0;
            dac_restore <= 1'b0;
        end else begin
            dac_out_en  <= !in_standby && dac_running && !dac_busy
                        && !(leave_stab && dac_was_reg);
            dac_restore <= dac_done;
        end
    end

    // Set beats software clear so an entry is never missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_result_invalid <= 1'b0;
            adc_first_reg      <= 1'b0;
            adc_sticky_reg     <= 1'b0;
            adc_restart        <= 1'b0;
        end else begin
            adc_restart <= leave_stab && adc_was_reg;
            if (enter_stop && adc_running) begin
                adc_result_invalid <= 1'b1;
                adc_sticky_reg     <= level_reg == LEVEL_LOWV;
                adc_first_reg      <= 1'b1;
            end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_ADC_INV]) begin
                adc_result_invalid <= 1'b0;
                adc_sticky_reg     <= 1'b0;
                adc_first_reg      <= 1'b0;
            end else if (state_reg == SSC_RUN && adc_conv_done) begin
                if (adc_first_reg) begin
                    adc_first_reg <= 1'b0;
                end else if (!adc_sticky_reg) begin
                    adc_result_invalid <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // APB slave, one wait-free access with registered read data
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        rd_err = 1'b0;
        if (paddr == OFF_CTRL) begin
            rd_mux[CTRL_SUB] = sub_used_reg;
        end else if (paddr == OFF_LEVEL) begin
            rd_mux[7:0] = level_reg;
        end else if (paddr == OFF_CLKSEL) begin
            rd_mux[4:0] = clksel_reg;
        end else if (paddr == OFF_WAKEDIS) begin
            rd_mux[2:0] = wakedis_reg;
        end else if (paddr == OFF_OSTCNT) begin
            rd_mux[SSC_CNT_W-1:0] = ost_reg;
        end else if (paddr == OFF_STATUS) begin
            rd_mux[ST_STATE_LSB +: 3] = state_reg;
            rd_mux[ST_LOWV]           = lowv_reg;
            rd_mux[ST_ADC_INV]        = adc_result_invalid;
            rd_mux[ST_ABORT]          = abort_reg;
            rd_mux[ST_CAUSE_LSB +: 2] = cause_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable && !pready;
            if (psel && !penable) begin
                prdata  <= pwrite ? '0 : rd_mux;
                pslverr <= rd_err;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_used_reg <= 1'b0;
            level_reg    <= LEVEL_RST;
            clksel_reg   <= '0;
            wakedis_reg  <= '0;
            ost_reg      <= OST_DEFAULT;
        end else if (wr_en && state_reg == SSC_RUN) begin
            if (paddr == OFF_CTRL) begin
                sub_used_reg <= pwdata[CTRL_SUB];
            end else if (paddr == OFF_LEVEL) begin
                level_reg <= pwdata[7:0];
            end else if (paddr == OFF_CLKSEL) begin
                clksel_reg <= pwdata[4:0];
            end else if (paddr == OFF_WAKEDIS) begin
                wakedis_reg <= pwdata[2:0];
            end else if (paddr == OFF_OSTCNT) begin
                ost_reg <= pwdata[SSC_CNT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    abort_no_entry_a: assert property (
        state_reg == SSC_RUN && stop_cmd && wake_now |=> state_reg == SSC_RUN ##0 stop_aborted)
        else $error("stop entered with wake pending");
    lowv_select_a: assert property (
        enter_stop && level_reg == LEVEL_LOWV |=> lowv_reg ##0 unit_ctl.regulator_low)
        else $error("low-voltage stop not selected");
    reg_restore_a: assert property (
        release_irq |=> !unit_ctl.regulator_low ##1 !unit_ctl.regulator_low)
        else $error("regulator not back to normal");
    wake_exit_a: assert property (
        release_irq |=> state_reg == SSC_STAB)
        else $error("wake did not leave stop");
    reset_exit_a: assert property (
        state_reg != SSC_RUN && rst_now |=> state_reg == SSC_RUN && reset_proc_req)
        else $error("reset did not end standby");
    stab_wait_a: assert property (
        release_irq && ost_reg > SSC_CNT_W'(2) |=> unit_ctl.cpu_halt [*2])
        else $error("cpu resumed before stabilization");
    dac_float_a: assert property (
        state_reg == SSC_STOP && !rst_now |=> !dac_out_en && unit_ctl.dac_halt)
        else $error("dac driven in stop");
    adc_invalid_a: assert property (
        enter_stop && adc_running |=> adc_result_invalid ##0 unit_ctl.adc_halt)
        else $error("adc result not flagged");
    watch_stop_a: assert property (
        state_reg == SSC_STOP && !rst_now && !(sub_used_reg && clksel_reg[CS_WT_SUB])
        |=> !unit_ctl.watch_run)
        else $error("watch timer runs in stop");
    output_hold_a: assert property (
        $rose(state_reg == SSC_STOP) && !rst_now
        |=> unit_ctl.realtime_out_hold && unit_ctl.port_hold)
        else $error("outputs not held in stop");

    cover_wake_c:  cover property (release_irq ##[1:300] leave_stab);
    cover_reset_c: cover property (state_reg == SSC_STOP && rst_now);
    cover_abort_c: cover property (stop_aborted);
    cover_lowv_c:  cover property (enter_stop && level_reg == LEVEL_LOWV);
endmodule
`default_nettype wire

/* testbench/ssc_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ssc_periph_model
    import ssc_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire ssc_unit_ctl_t unit_ctl,
    output var  logic          adc_running,
    output var  logic          adc_conv_done,
    output var  logic          dac_running
);
    logic [3:0] div_reg;
    // Converters always busy; no external serial clock is ever supplied
    assign adc_running = 1'b1;
    assign dac_running = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_reg <= 4'h0;
        else div_reg <= div_reg + 4'h1;
    end
    // One result every 16 cycles, none while halted
    assign adc_conv_done = div_reg == 4'hf && !unit_ctl.adc_halt;
endmodule
`default_nettype wire

/* testbench/tb_stop_mode_standby_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_stop_mode_standby_control;
    import ssc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [SSC_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, ost, m;
    logic pready, pslverr, adc_running, adc_conv_done, dac_running, adc_restart;
    logic adc_result_invalid, dac_out_en, dac_restore, reset_proc_req, stop_aborted;
    logic [32:0] e, exp_q[$];
    logic [31:0] msk_q[$];
    ssc_wake_src_t wake_src = '0;
    ssc_reset_src_t reset_src = '0;
    ssc_unit_ctl_t unit_ctl;
    int errors = 0, n_compared = 0, i, k, n_restart = 0, n_abort = 0;
    always #50 pclk = ~pclk;
    ssc_standby_ctrl #(.OST_DEFAULT(16'h0008)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_src, .reset_src, .adc_running,
        .adc_conv_done, .dac_running, .unit_ctl, .adc_restart, .adc_result_invalid,
        .dac_out_en, .dac_restore, .reset_proc_req, .stop_aborted);
    ssc_periph_model pm (.pclk, .presetn, .unit_ctl, .adc_running, .adc_conv_done, .dac_running);
    task automatic tally_and_finish();
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic ex, input logic got);
        n_compared++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s exp %b got %b", nm, ex, got);
        end
    endtask
    task automatic guard(inout int n);
        @(posedge pclk);
        n++;
        if (n > 400) begin
            errors++;
            $display("MISMATCH timeout exp %0d got %0d", 400, n);
            tally_and_finish();
        end
    endtask
    // Reads note the expected word; the watcher below compares
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] ex, input logic [31:0] mk);
        int n;
        if (!w) exp_q.push_back(ex);
        if (!w) msk_q.push_back(mk);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do guard(n); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk) begin
        if (adc_restart === 1'b1) n_restart++;
        if (stop_aborted === 1'b1) n_abort++;
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            n_compared++;
            if (({pslverr, prdata} & {1'b1, m}) !== e) begin
                errors++;
                $display("MISMATCH read %h exp %h got %h", paddr, e, {pslverr, prdata & m});
            end
        end
    end
    initial begin
        void'($urandom(47775));
        ost = $urandom_range(12, 6);
        k = $urandom_range(7, 0);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_OSTCNT, 0, {1'b0, 32'h8}, 32'hffff);
        apb(0, OFF_STATUS, 0, {1'b0, 32'h1}, 32'h377);
        apb(0, 8'h18, 0, {1'b1, 32'h0}, 32'h0);
        apb(1, OFF_OSTCNT, ost, '0, '0);
        wake_src.external_interrupt_pin[k] <= 1'b1;
        apb(1, OFF_CTRL, 32'h1, '0, '0);
        apb(0, OFF_STATUS, 0, {1'b0, 32'h41}, 32'h47);
        apb(1, OFF_STATUS, 32'h40, '0, '0);
        apb(1, OFF_LEVEL, 32'h1, '0, '0);
        apb(1, OFF_CLKSEL, 32'h1, '0, '0);
        apb(1, OFF_WAKEDIS, 32'h4, '0, '0);
        apb(1, OFF_CTRL, 32'h1, '0, '0);
        repeat (20) @(posedge pclk);
        #1;
        chk("cpu_halt", 1, unit_ctl.cpu_halt);
        chk("regulator_low", 1, unit_ctl.regulator_low);
        chk("port_hold", 1, unit_ctl.port_hold);
        chk("itimer_run", 1, unit_ctl.itimer_run);
        chk("wdt_run", 0, unit_ctl.wdt_run);
        chk("watch_run", 0, unit_ctl.watch_run);
        chk("dac_out_en", 0, dac_out_en);
        chk("adc_invalid", 1, adc_result_invalid);
        chk("osc_stop", 1, unit_ctl.osc_stop);
        chk("serial_halt", 1, unit_ctl.serial_halt);
        chk("adc_halt", 1, unit_ctl.adc_halt);
        chk("dac_halt", 1, unit_ctl.dac_halt);
        @(posedge pclk);
        wake_src.nmi_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("regulator_back", 0, unit_ctl.regulator_low);
        i = 0;
        while (unit_ctl.cpu_halt !== 1'b0) guard(i);
        chk("ost_wait", 1, i >= ost - 1 && i <= ost + 1);
        wake_src <= '0;
        apb(0, OFF_STATUS, 0, {1'b0, 32'h121}, 32'h327);
        i = 0;
        while (dac_restore !== 1'b1) guard(i);
        @(posedge pclk);
        #1;
        chk("dac_restored", 1, dac_out_en);
        apb(1, OFF_WAKEDIS, 32'h0, '0, '0);
        apb(1, OFF_LEVEL, 32'h0, '0, '0);
        apb(1, OFF_CLKSEL, 32'h18, '0, '0);
        apb(1, OFF_CTRL, 32'h3, '0, '0);
        repeat (3) @(posedge pclk);
        #1;
        chk("plain_reg", 0, unit_ctl.regulator_low);
        chk("watch_sub", 1, unit_ctl.watch_run);
        chk("wdt_sub", 1, unit_ctl.wdt_run);
        chk("realtime_out_hold", 1, unit_ctl.realtime_out_hold);
        chk("intc_stop", 1, unit_ctl.intc_stop);
        @(posedge pclk);
        reset_src.watchdog_reset_event <= 1'b1;
        i = 0;
        while (reset_proc_req !== 1'b1) guard(i);
        reset_src <= '0;
        apb(0, OFF_STATUS, 0, {1'b0, 32'h201}, 32'h307);
        repeat (40) @(posedge pclk);
        #1;
        chk("adc_valid_again", 0, adc_result_invalid);
        chk("adc_restart", 1, n_restart == 1);
        chk("stop_aborted", 1, n_abort == 1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
